// ---- design/prioritized_interrupt_controller.sv ----
// vectored interrupt controller with four nesting levels
// assumes cpu pulses ack on entry and return on exit, same clock
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps

// What this block does
// R1: fifteen sources, each with a two-bit software priority field.
// R2: levels rank 0 lowest to 3 highest; all reset to 0.
// R3: hardware sets a source flag when its condition occurs.
// R4: request needs global enable, source enable and source flag.
// R5: global enable low blocks every request to the cpu.
// R6: higher level preempts a lower running routine; lower waits.
// R7: equal level never preempts the running routine.
// R8: highest level wins; ties go to lower order number.
// R9: vectors 0x0003 plus eight per order; order 12 reserved.
// R10: reset ranks highest, vector 0x0000, always on, no level.
// R11: flags set while disabled stay pending.
// R12: enabling a pending source enters at once; clear flag first.
// R13: both external groups trigger on rise, fall or either.
// R14: group zero picks one of port-zero pins or comparator.
// R15: group zero has its own edge field and priority field.
// R16: group one has sixteen pins with own flags and enables.
// R17: software sets group one enable before pin enables.
// R18: group one shares one edge field and own priority field.
// R19: edge code 00 rise, 01 fall, 1x either.
// R20: writing zero clears an external or thermal flag.
// R21: active levels are recorded and released on return.
// R22: inputs sampled on clock; edge against previous sample.
module prioritized_interrupt_controller
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   // source events and pins
   input  wire logic        thermal_event_i,
   input  wire logic [15:3] periph_event_i,
   input  wire logic [6:0]  port_zero_pin_i,
   input  wire logic        comparator_four_output_i,
   input  wire logic [7:0]  port_one_pin_i,
   input  wire logic [7:0]  port_two_pin_i,
   // cpu side
   input  wire logic        irq_ack_i,
   input  wire logic        irq_return_i,
   output logic             irq_req_o,
   output logic      [15:0] irq_vector_o
);

   // ==================================================
   // state
   typedef struct packed
   {
      logic [7:0]  irq_enable_reg;
      logic [7:0]  priority_reg_a;
      logic [7:0]  priority_reg_b;
      logic [7:0]  priority_reg_c;
      logic [7:0]  priority_reg_d;
      logic [7:0]  ext_control_reg;
      logic [7:0]  port_one_pin_enables;
      logic [7:0]  port_one_pin_flags;
      logic [7:0]  port_two_pin_enables;
      logic [7:0]  port_two_pin_flags;
      logic [2:0]  ext_group0_source_sel;
      logic [15:0] src_flags;
      logic [15:0] src_enables;
      logic [3:0]  active;
      logic [1:0]  win_level;
      logic        req;
      logic [15:0] vector;
      logic [7:0]  rdata;
   } ctrl_state_t;

   typedef struct packed
   {
      logic       found;
      logic [3:0] order;
      logic [1:0] level;
   } winner_t;

   ctrl_state_t st_q;
   ctrl_state_t st_d;

   // ==================================================
   // helpers
   function automatic logic [7:0] clear_on_zero(
      input logic [7:0] cur,
      input logic [7:0] wr_val,
      input logic       wr_en,
      input logic [7:0] set
   );
      logic [7:0] kept;
      kept = wr_en ? (cur & wr_val) : cur;
      return kept | set; // R20
   endfunction

   function automatic logic [1:0] top_level(input logic [3:0] act);
      logic [1:0] lv;
      lv = 2'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (act[i])
            lv = 2'(i);
      end
      return lv;
   endfunction

   function automatic winner_t arbitrate(
      input logic [15:0] pend,
      input logic [31:0] prio
   );
      winner_t w;
      logic [1:0] lv;
      w = '0;
      // walk downward so ties fall to the lower order
      for (int i = NUM_ORDERS - 1; i >= 0; i--)
      begin
         lv = prio[2*i +: 2];
         if (pend[i] && (!w.found || lv >= w.level)) // R8
         begin
            w.found = 1'b1;
            w.order = 4'(i);
            w.level = lv;
         end
      end
      return w;
   endfunction

   // ==================================================
   // edge detectors
   edge_if #(.N(G0_INPUTS)) g0_eb ();
   edge_if #(.N(G1_INPUTS)) g1_eb ();

   assign g0_eb.edge_sel = st_q.ext_control_reg[POS_G0_EDGE +: 2]; // R15
   assign g1_eb.edge_sel = st_q.ext_control_reg[POS_G1_EDGE +: 2]; // R18

   pin_edge_detect #(.N(G0_INPUTS)) u_g0_det
   (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .pin_i   ({comparator_four_output_i, port_zero_pin_i}),
      .eb      (g0_eb)
   );

   pin_edge_detect #(.N(G1_INPUTS)) u_g1_det
   (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .pin_i   ({port_two_pin_i, port_one_pin_i}),
      .eb      (g1_eb)
   );

   // ==================================================
   // pending sources and arbitration
   logic        g0_evt;
   logic [15:0] pend;
   logic [31:0] prio_all;
   logic        g1_any;
   winner_t     win;
   logic        may_enter;

   always_comb
   begin
      // edges of every candidate are tracked, so changing the
      // selection does not fake an edge
      g0_evt   = g0_eb.evt[st_q.ext_group0_source_sel]; // R14
      g1_any   = |((st_q.port_one_pin_flags & st_q.port_one_pin_enables) |
                   (st_q.port_two_pin_flags & st_q.port_two_pin_enables)); // R16
      pend     = st_q.src_flags & st_q.src_enables & RSV_MASK; // R9
      pend[0]  = st_q.ext_control_reg[BIT_THERM_FLG] &
                 st_q.irq_enable_reg[BIT_THERM_EN];
      pend[1]  = st_q.ext_control_reg[BIT_G0_FLG] &
                 st_q.irq_enable_reg[BIT_G0_EN];
      pend[2]  = g1_any & st_q.irq_enable_reg[BIT_G1_EN]; // R17
      prio_all = {st_q.priority_reg_d, st_q.priority_reg_c,
                  st_q.priority_reg_b, st_q.priority_reg_a}; // R1
      win      = arbitrate(pend, prio_all);
      may_enter = win.found && (st_q.active == 4'h0 ||
                  win.level > top_level(st_q.active)); // R6 R7
   end

   // ==================================================
   // next state
   logic wr_ext;

   always_comb
   begin
      st_d   = st_q;
      wr_ext = wr_i && addr_i == ADDR_EXT_CTRL;

      // flags: hardware set wins over a software clear
      st_d.ext_control_reg = wr_ext ? {2'h0, wdata_i[5:0]} : st_q.ext_control_reg;
      st_d.ext_control_reg[BIT_THERM_FLG] = (st_q.ext_control_reg[BIT_THERM_FLG] &
         ~(wr_ext & ~wdata_i[BIT_THERM_FLG])) | thermal_event_i; // R3 R20
      st_d.ext_control_reg[BIT_G0_FLG] = (st_q.ext_control_reg[BIT_G0_FLG] &
         ~(wr_ext & ~wdata_i[BIT_G0_FLG])) | g0_evt; // R3 R20 R22
      st_d.port_one_pin_flags = clear_on_zero(st_q.port_one_pin_flags, wdata_i,
         wr_i && addr_i == ADDR_P1_FLAG, g1_eb.evt[7:0]); // R16 R11
      st_d.port_two_pin_flags = clear_on_zero(st_q.port_two_pin_flags, wdata_i,
         wr_i && addr_i == ADDR_P2_FLAG, g1_eb.evt[15:8]); // R16 R11
      st_d.src_flags[7:0] = clear_on_zero(st_q.src_flags[7:0], wdata_i,
         wr_i && addr_i == ADDR_SRC_FLG_L, {periph_event_i[7:3], 3'h0}); // R3
      st_d.src_flags[15:8] = clear_on_zero(st_q.src_flags[15:8], wdata_i,
         wr_i && addr_i == ADDR_SRC_FLG_H, periph_event_i[15:8] & RSV_MASK[15:8]);

      // plain control registers
      if (wr_i)
      begin
         unique case (addr_i)
            ADDR_IRQ_EN:    st_d.irq_enable_reg = wdata_i & 8'hdf;
            ADDR_PRIO_A:    st_d.priority_reg_a = wdata_i;
            ADDR_PRIO_B:    st_d.priority_reg_b = wdata_i;
            ADDR_PRIO_C:    st_d.priority_reg_c = wdata_i;
            ADDR_PRIO_D:    st_d.priority_reg_d = wdata_i & 8'hfc;
            ADDR_P1_EN:     st_d.port_one_pin_enables = wdata_i;
            ADDR_P2_EN:     st_d.port_two_pin_enables = wdata_i;
            ADDR_G0_SEL:    st_d.ext_group0_source_sel = wdata_i[2:0];
            ADDR_SRC_EN_L:  st_d.src_enables[7:0] = wdata_i & 8'hf8;
            ADDR_SRC_EN_H:  st_d.src_enables[15:8] = wdata_i & RSV_MASK[15:8];
            default:        st_d.src_enables = st_q.src_enables;
         endcase
      end

      // read data stands one cycle, zero otherwise
      st_d.rdata = 8'h00;
      if (rd_i)
      begin
         unique case (addr_i)
            ADDR_EXT_CTRL:  st_d.rdata = st_q.ext_control_reg;
            ADDR_IRQ_EN:    st_d.rdata = st_q.irq_enable_reg;
            ADDR_PRIO_A:    st_d.rdata = st_q.priority_reg_a;
            ADDR_PRIO_B:    st_d.rdata = st_q.priority_reg_b;
            ADDR_PRIO_C:    st_d.rdata = st_q.priority_reg_c;
            ADDR_PRIO_D:    st_d.rdata = st_q.priority_reg_d;
            ADDR_P1_EN:     st_d.rdata = st_q.port_one_pin_enables;
            ADDR_P1_FLAG:   st_d.rdata = st_q.port_one_pin_flags;
            ADDR_P2_EN:     st_d.rdata = st_q.port_two_pin_enables;
            ADDR_P2_FLAG:   st_d.rdata = st_q.port_two_pin_flags;
            ADDR_G0_SEL:    st_d.rdata = {5'h00, st_q.ext_group0_source_sel};
            ADDR_SRC_FLG_L: st_d.rdata = st_q.src_flags[7:0];
            ADDR_SRC_FLG_H: st_d.rdata = st_q.src_flags[15:8];
            ADDR_SRC_EN_L:  st_d.rdata = st_q.src_enables[7:0];
            ADDR_SRC_EN_H:  st_d.rdata = st_q.src_enables[15:8];
            default:        st_d.rdata = 8'h00;
         endcase
      end

      // nesting record: return first, then a new entry
      if (irq_return_i && st_q.active != 4'h0)
         st_d.active[top_level(st_q.active)] = 1'b0; // R21
      if (irq_ack_i && st_q.req)
         st_d.active[st_q.win_level] = 1'b1; // R21

      // request and vector; vector holds while idle
      st_d.req       = st_q.irq_enable_reg[BIT_GLOBAL_EN] && may_enter; // R4 R5 R12
      st_d.win_level = win.level;
      if (win.found)
         st_d.vector = VEC_BASE + {9'h000, win.order, 3'h0}; // R9
   end

   // ==================================================
   // registers
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q        <= '0; // R2
         st_q.vector <= RESET_VEC; // R10
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign rdata_o      = st_q.rdata;
   assign irq_req_o    = st_q.req;
   assign irq_vector_o = st_q.vector;

   // ==================================================
   // checks
   global_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
      !st_q.irq_enable_reg[BIT_GLOBAL_EN] |=> !irq_req_o)
      else $error("request with global enable off");

   req_cause_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
      irq_req_o |-> $past(pend) != 16'h0000)
      else $error("request without enabled pending flag");

   vector_form_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R9
      irq_req_o |-> irq_vector_o[2:0] == 3'h3 && irq_vector_o != 16'h0063)
      else $error("bad vector");

   nest_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
      (irq_req_o && st_q.active != 4'h0) |-> st_q.win_level > top_level(st_q.active)
      || $past(st_q.active) != st_q.active)
      else $error("equal level would preempt");

   flag_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
      (st_q.ext_control_reg[BIT_G0_FLG] && !(wr_i && addr_i == ADDR_EXT_CTRL))
      |=> st_q.ext_control_reg[BIT_G0_FLG])
      else $error("pending flag lost");

   edge_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R22
      g0_evt |=> st_q.ext_control_reg[BIT_G0_FLG])
      else $error("group zero edge not flagged");

   zero_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R20
      (wr_i && addr_i == ADDR_EXT_CTRL && !wdata_i[BIT_THERM_FLG] && !thermal_event_i)
      |=> !st_q.ext_control_reg[BIT_THERM_FLG])
      else $error("write zero did not clear");

   ack_record_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R21
      (irq_ack_i && irq_req_o) |=> st_q.active[$past(st_q.win_level)])
      else $error("entry not recorded");

   tie_order_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R8
      ($past(pend[1]) && $past(pend[2]) && $past(prio_all[3:2]) == $past(prio_all[5:4])
      && irq_req_o) |-> irq_vector_o != 16'h0013)
      else $error("higher order won a tie");

endmodule

// ---- inc/irq_ctrl_pkg.sv ----
// constants shared by the interrupt controller files
// assumes an 8-bit register port with byte-wide addresses
package irq_ctrl_pkg;

   // ==================================================
   // register addresses
   localparam logic [7:0] ADDR_EXT_CTRL  = 8'h88;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'ha8;
   localparam logic [7:0] ADDR_PRIO_A    = 8'hb8;
   localparam logic [7:0] ADDR_PRIO_B    = 8'hc0;
   localparam logic [7:0] ADDR_PRIO_C    = 8'hc8;
   localparam logic [7:0] ADDR_PRIO_D    = 8'hd8;
   localparam logic [7:0] ADDR_P1_EN     = 8'hd1;
   localparam logic [7:0] ADDR_P1_FLAG   = 8'hd2;
   localparam logic [7:0] ADDR_P2_EN     = 8'hd3;
   localparam logic [7:0] ADDR_P2_FLAG   = 8'hd4;
   localparam logic [7:0] ADDR_G0_SEL    = 8'he0;
   localparam logic [7:0] ADDR_SRC_FLG_L = 8'he1;
   localparam logic [7:0] ADDR_SRC_FLG_H = 8'he2;
   localparam logic [7:0] ADDR_SRC_EN_L  = 8'he3;
   localparam logic [7:0] ADDR_SRC_EN_H  = 8'he4;

   // ==================================================
   // field positions
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_G1_EN     = 2;
   localparam int BIT_THERM_EN  = 1;
   localparam int BIT_G0_EN     = 0;
   localparam int BIT_THERM_FLG = 5;
   localparam int BIT_G0_FLG    = 2;
   localparam int POS_G1_EDGE   = 3;
   localparam int POS_G0_EDGE   = 0;

   // ==================================================
   // reset values, vectors, sources
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [15:0] RESET_VEC  = 16'h0000;
   localparam logic [15:0] VEC_BASE   = 16'h0003;
   localparam int          NUM_ORDERS = 16;
   localparam logic [15:0] RSV_MASK   = 16'hefff;
   localparam int          G0_INPUTS  = 8;
   localparam int          G1_INPUTS  = 16;

   typedef enum logic [1:0]
   {
      EDGE_RISE = 2'b00,
      EDGE_FALL = 2'b01
   } edge_mode_t;

endpackage

// ---- inc/edge_if.sv ----
// carrier between the controller and its edge detector
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface edge_if #(parameter int N = 8);
   logic [1:0]   edge_sel;
   logic [N-1:0] evt;

   modport det (input edge_sel, output evt);
   modport ctl (output edge_sel, input evt);
endinterface

// ---- design/pin_edge_detect.sv ----
// synchroniser and edge detector for a group of pins
// assumes pins are asynchronous to mclk_i
`timescale 1ns/1ps
module pin_edge_detect
   import irq_ctrl_pkg::*;
#(
   parameter int N = 8
)
(
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   // pins
   input  wire logic [N-1:0] pin_i,
   // carrier
   edge_if.det               eb
);

   // ==================================================
   // state
   typedef struct packed
   {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] prev;
      logic [N-1:0] evt;
   } det_state_t;

   det_state_t st_q;
   det_state_t st_d;

   // s1 feeds s2 only; edges are taken on s2 vs prev
   always_comb
   begin
      st_d      = st_q;
      st_d.s1   = pin_i;
      st_d.s2   = st_q.s1;
      st_d.prev = st_q.s2;
      if (eb.edge_sel[1])
         st_d.evt = st_q.s2 ^ st_q.prev; // R13 R19 R22
      else if (eb.edge_sel == EDGE_FALL)
         st_d.evt = ~st_q.s2 & st_q.prev; // R19
      else
         st_d.evt = st_q.s2 & ~st_q.prev; // R19
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign eb.evt = st_q.evt;

   rise_event_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R19
      (eb.edge_sel == EDGE_RISE && st_q.s2[0] && !st_q.prev[0]) |=> eb.evt[0])
      else $error("rising edge gave no event");

endmodule

// ---- bench/cpu_core_model.sv ----
// cpu core model: takes vectored requests, returns on command
// assumes the controller clock and its active-low async reset
`timescale 1ns/1ps
module cpu_core_model
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // controller side
   input  wire logic        irq_req_i,
   input  wire logic [15:0] irq_vector_i,
   output logic             irq_ack_o,
   output logic             irq_return_o,
   // bench control
   input  wire logic        take_en_i,
   input  wire logic [1:0]  ack_delay_i,
   input  wire logic        ret_go_i,
   output logic      [15:0] last_vec_o,
   output logic      [6:0]  entries_o
);
   // ==================================================
   // entry and return
   logic [1:0] wait_q;
   logic [1:0] hold_q;

   // request may linger a cycle after ack, so pause before the next
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         irq_ack_o    <= 1'b0;
         irq_return_o <= 1'b0;
         last_vec_o   <= 16'h0000;
         entries_o    <= 7'h00;
         wait_q       <= 2'h0;
         hold_q       <= 2'h0;
      end
      else
      begin
         irq_ack_o    <= 1'b0;
         irq_return_o <= ret_go_i;
         if (hold_q != 2'h0)
            hold_q <= hold_q - 2'h1;
         if (!irq_req_i || !take_en_i || hold_q != 2'h0)
            wait_q <= 2'h0;
         else if (wait_q != ack_delay_i)
            wait_q <= wait_q + 2'h1;
         else
         begin
            irq_ack_o  <= 1'b1;
            last_vec_o <= irq_vector_i;
            entries_o  <= entries_o + 7'h01;
            hold_q     <= 2'h3;
            wait_q     <= 2'h0;
         end
      end
   end
endmodule

// ---- bench/prioritized_interrupt_controller_tb_top.sv ----
// bench top: random and corner stimulus, self-checking
// assumes package, carrier and design compiled first
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb_top
   import irq_ctrl_pkg::*;
;
   // ==================================================
   // signals
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        therm = 1'b0;
   logic [15:3] pev = '0;
   logic [6:0]  p0 = 7'h00;
   logic        comparator_four_output = 1'b0;
   logic [7:0]  p1 = 8'h00;
   logic [7:0]  p2 = 8'h00;
   logic        take_en = 1'b0;
   logic [1:0]  dly = 2'h0;
   logic        ret_go = 1'b0;
   logic [7:0]  rdata;
   logic        ack;
   logic        ret;
   logic        req;
   logic [15:0] vec;
   logic [15:0] last_vec;
   logic [6:0]  entries;
   logic [15:0] g1m;
   logic [31:0] pr;
   logic [12:0] ev;
   logic [15:0] pend;
   logic [15:0] hold_vec = 16'h0000;
   logic        fl;
   int          bad_count = 0;
   int          total_checks = 0;
   int          seed = 32'h4213;
   int          s;
   int          w;
   // unmapped address last; flag registers read back zero after writes
   logic [7:0]  ra [16] = '{ADDR_EXT_CTRL, ADDR_IRQ_EN, ADDR_PRIO_A, ADDR_PRIO_B,
      ADDR_PRIO_C, ADDR_PRIO_D, ADDR_P1_EN, ADDR_P2_EN, ADDR_G0_SEL, ADDR_SRC_EN_L,
      ADDR_SRC_EN_H, ADDR_P1_FLAG, ADDR_P2_FLAG, ADDR_SRC_FLG_L, ADDR_SRC_FLG_H, 8'h00};
   logic [7:0]  rm [16] = '{8'h1b, 8'hdf, 8'hff, 8'hff, 8'hff, 8'hfc, 8'hff, 8'hff,
      8'h07, 8'hf8, 8'hef, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   always #5 mclk_i = ~mclk_i;

   prioritized_interrupt_controller u_prioritized_interrupt_controller
   (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .thermal_event_i(therm),
      .periph_event_i(pev), .port_zero_pin_i(p0), .comparator_four_output_i(comparator_four_output),
      .port_one_pin_i(p1), .port_two_pin_i(p2), .irq_ack_i(ack),
      .irq_return_i(ret), .irq_req_o(req), .irq_vector_o(vec)
   );

   cpu_core_model u_cpu_core_model
   (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .irq_req_i(req), .irq_vector_i(vec),
      .irq_ack_o(ack), .irq_return_o(ret), .take_en_i(take_en), .ack_delay_i(dly),
      .ret_go_i(ret_go), .last_vec_o(last_vec), .entries_o(entries)
   );

   // ==================================================
   // expectations
   function automatic logic [15:0] vec_of(input int n);
      return VEC_BASE + 16'(8 * n);
   endfunction

   // strict greater keeps the lower order on a level tie
   function automatic int pick(input logic [15:0] pd, input logic [31:0] pv);
      int best;
      int lvl;
      best = -1;
      lvl = -1;
      for (int n = 0; n < NUM_ORDERS; n++)
         if (pd[n] && int'(pv[2*n +: 2]) > lvl)
         begin
            best = n;
            lvl = int'(pv[2*n +: 2]);
         end
      return best;
   endfunction

   // ==================================================
   // bus and stimulus tasks
   task automatic chk_val(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1;
      chk_val({16'h0000, rdata}, {16'h0000, e});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic pulse_src(input logic t, input logic [12:0] e);
      @(posedge mclk_i);
      therm <= t;
      pev <= e;
      @(posedge mclk_i);
      therm <= 1'b0;
      pev <= '0;
   endtask

   task automatic ret_pulse();
      @(posedge mclk_i);
      ret_go <= 1'b1;
      @(posedge mclk_i);
      ret_go <= 1'b0;
   endtask

   // only the selected candidate and pin move; all others stay low
   task automatic set_pins(input logic lv);
      @(posedge mclk_i);
      {comparator_four_output, p0} <= lv ? (8'h01 << s) : 8'h00;
      {p2, p1} <= lv ? g1m : 16'h0000;
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==================================================
   // scenarios
   initial
   begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      settle(1);
      chk_val({7'h0, req, vec}, {7'h0, 1'b0, RESET_VEC});
      foreach (ra[i]) rd_chk(ra[i], 8'h00);
      foreach (ra[i])
      begin
         pr = $random(seed);
         wr_reg(ra[i], pr[7:0]);
         rd_chk(ra[i], pr[7:0] & rm[i]);
         wr_reg(ra[i], 8'h00);
      end
      pulse_src(1'b1, 13'h0000);
      settle(2);
      chk_val({7'h0, req, vec}, 24'h0);
      rd_chk(ADDR_EXT_CTRL, 8'h20);
      wr_reg(ADDR_IRQ_EN, 8'h02);
      settle(3);
      // vector tracks the winner even while the global gate is shut
      chk_val({7'h0, req, vec}, {7'h0, 1'b0, vec_of(0)});
      wr_reg(ADDR_IRQ_EN, 8'h82);
      settle(3);
      chk_val({7'h0, req, vec}, {7'h0, 1'b1, vec_of(0)});
      wr_reg(ADDR_EXT_CTRL, 8'h20);
      rd_chk(ADDR_EXT_CTRL, 8'h20);
      wr_reg(ADDR_EXT_CTRL, 8'h00);
      settle(3);
      chk_val({7'h0, req, vec}, {7'h0, 1'b0, vec_of(0)});
      wr_reg(ADDR_SRC_EN_L, 8'hff);
      wr_reg(ADDR_SRC_EN_H, 8'hff);
      // first two trials: every peripheral event source at once, all levels equal
      for (int t = 0; t < 24; t++)
      begin
         pr = (t < 2) ? {32{t[0]}} : $random(seed);
         ev = (t < 2) ? 13'h1fff : 13'($random(seed));
         for (int k = 0; k < 4; k++)
            wr_reg(ra[k + 2], pr[8*k +: 8]);
         pulse_src(1'b0, ev);
         pend = {ev, 3'b000} & RSV_MASK;
         w = pick(pend, pr);
         if (w >= 0)
            hold_vec = vec_of(w);
         settle(3);
         chk_val({7'h0, req, vec}, {7'h0, pend != 16'h0000, hold_vec});
         wr_reg(ADDR_SRC_FLG_L, 8'h00);
         wr_reg(ADDR_SRC_FLG_H, 8'h00);
         // upper flags stand alone for two cycles between the two clears
         w = pick(pend & 16'hff00, pr);
         if (w >= 0)
            hold_vec = vec_of(w);
      end
      wr_reg(ADDR_PRIO_A, 8'h40);
      wr_reg(ADDR_PRIO_B, 8'h09);
      wr_reg(ADDR_PRIO_C, 8'h00);
      wr_reg(ADDR_PRIO_D, 8'h00);
      take_en <= 1'b1;
      dly <= 2'($random(seed));
      pulse_src(1'b0, 13'h0001);
      settle(8);
      chk_val({entries, req, last_vec}, {7'd1, 1'b0, vec_of(3)});
      pulse_src(1'b0, 13'h0002);
      settle(8);
      chk_val({entries, req, last_vec}, {7'd1, 1'b0, vec_of(3)});
      pulse_src(1'b0, 13'h0004);
      settle(8);
      chk_val({entries, req, last_vec}, {7'd2, 1'b0, vec_of(5)});
      wr_reg(ADDR_SRC_FLG_L, 8'h18);
      ret_pulse();
      settle(8);
      chk_val({entries, req, last_vec}, {7'd2, 1'b0, vec_of(5)});
      wr_reg(ADDR_SRC_FLG_L, 8'h10);
      ret_pulse();
      settle(8);
      chk_val({entries, req, last_vec}, {7'd3, 1'b0, vec_of(4)});
      take_en <= 1'b0;
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      settle(2);
      chk_val({entries, req, vec}, 24'h0);
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd_chk(ADDR_PRIO_B, 8'h00);
      s = $random(seed) & 7;
      g1m = 16'h0001 << ($random(seed) & 15);
      wr_reg(ADDR_G0_SEL, 8'(s));
      for (int m = 0; m < 4; m++)
         for (int e = 1; e >= 0; e--)
         begin
            wr_reg(ADDR_EXT_CTRL, {3'b000, 2'(m), 1'b0, 2'(m)});
            wr_reg(ADDR_P1_FLAG, 8'h00);
            wr_reg(ADDR_P2_FLAG, 8'h00);
            set_pins(e[0]);
            settle(6);
            fl = e[0] ? (m != 1) : (m != 0);
            rd_chk(ADDR_EXT_CTRL, {3'b000, 2'(m), fl, 2'(m)});
            rd_chk(ADDR_P1_FLAG, fl ? g1m[7:0] : 8'h00);
            rd_chk(ADDR_P2_FLAG, fl ? g1m[15:8] : 8'h00);
         end
      wr_reg(ADDR_EXT_CTRL, 8'h00);
      wr_reg(ADDR_P1_FLAG, 8'h00);
      wr_reg(ADDR_P2_FLAG, 8'h00);
      wr_reg(ADDR_IRQ_EN, 8'h84);
      wr_reg(ADDR_P1_EN, g1m[7:0]);
      wr_reg(ADDR_P2_EN, g1m[15:8]);
      set_pins(1'b1);
      settle(8);
      chk_val({7'h0, req, vec}, {7'h0, 1'b1, vec_of(2)});
      // both groups pending at level 0: the lower order must win
      wr_reg(ADDR_IRQ_EN, 8'h85);
      settle(3);
      chk_val({7'h0, req, vec}, {7'h0, 1'b1, vec_of(1)});
      end_of_test();
   end

   // full run is under a thousand cycles; allow ample margin
   initial
   begin
      #400000;
      bad_count++;
      end_of_test();
   end
endmodule
